// ==== design/prg_pkg.sv ====
// constants and types shared by the random word gate and its health tests
package prg_pkg;

	// ****************************************************************
	// word and sampling
	// ****************************************************************
	localparam int unsigned PRG_WORD_W      = 32;  // delivered word width
	localparam int unsigned PRG_SAMPLE_DIV  = 4;   // clocks between raw samples
	localparam int unsigned PRG_DIV_W       = 8;

	// ****************************************************************
	// health test limits
	// ****************************************************************
	// repetition cutoff must stay below the word width (see gate top)
	localparam int unsigned PRG_RC_CUTOFF   = 24;
	localparam int unsigned PRG_RC_W        = 6;
	// proportion window and allowed count of ones in it
	localparam int unsigned PRG_WIN_LEN     = 1024;
	localparam int unsigned PRG_WIN_W       = 11;
	localparam int unsigned PRG_ONES_LO     = 400;
	localparam int unsigned PRG_ONES_HI     = 624;
	// clean windows needed before the power-up test passes
	localparam int unsigned PRG_PWRUP_WINS  = 2;
	localparam int unsigned PRG_PASS_W      = 4;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [31:0] PRG_WORD_RST    = 32'h0000_0000;

	// gate states
	typedef enum logic [1:0] {
		PRG_ST_TEST,
		PRG_ST_RUN,
		PRG_ST_DEAD
	} prg_state_t;

endpackage

// ==== design/prg_health_if.sv ====
// carrier between the gate top and the health test engine
`timescale 1ns/10ps
interface prg_health_if;
	logic sample_stb;   // one raw bit is presented this cycle
	logic sample_bit;   // synchronised raw bit
	logic restart;      // clear all test history
	logic total_fail;   // pulse: stuck source seen
	logic defect;       // pulse: window out of bounds
	logic win_ok;       // pulse: window closed clean

	modport gate (output sample_stb, output sample_bit, output restart,
		input total_fail, input defect, input win_ok);
	modport health (input sample_stb, input sample_bit, input restart,
		output total_fail, output defect, output win_ok);
endinterface

// ==== design/prg_health.sv ====
// health test engine: repetition count and proportion window on raw bits
`timescale 1ns/10ps
module prg_health
	import prg_pkg::*;
(
	// clock and reset
	input  wire logic      clk_in,
	input  wire logic      reset_n_in,
	// link to gate
	prg_health_if.health   hif
);

	logic                last_q,  last_d;
	logic [PRG_RC_W-1:0] run_q,   run_d;
	logic [PRG_WIN_W-1:0] win_q,  win_d;
	logic [PRG_WIN_W-1:0] ones_q, ones_d;
	logic                fail_q,  fail_d;
	logic                def_q,   def_d;
	logic                ok_q,    ok_d;

	// ****************************************************************
	// next state
	// ****************************************************************
	// tests run on every sample, never on request, so latency is bounded
	always_comb begin
		last_d = last_q;
		run_d  = run_q;
		win_d  = win_q;
		ones_d = ones_q;
		fail_d = 1'b0;
		def_d  = 1'b0;
		ok_d   = 1'b0;
		if (!hif.restart && hif.sample_stb) begin  // [RL6]
			last_d = hif.sample_bit;
			// total failure: same bit repeated cutoff times
			if (hif.sample_bit == last_q) begin
				run_d = run_q + 1'b1;
			end else begin
				run_d = PRG_RC_W'(1);
			end
			if (run_d >= PRG_RC_W'(PRG_RC_CUTOFF)) begin
				fail_d = 1'b1;  // [RL1]
				run_d  = PRG_RC_W'(1);
			end
			// proportion of ones per window bounds bias, hence entropy
			ones_d = ones_q + {{(PRG_WIN_W-1){1'b0}}, hif.sample_bit};
			win_d  = win_q + 1'b1;
			if (win_q == PRG_WIN_W'(PRG_WIN_LEN - 1)) begin
				if (ones_d < PRG_WIN_W'(PRG_ONES_LO) ||
					ones_d > PRG_WIN_W'(PRG_ONES_HI)) begin
					def_d = 1'b1;  // [RL4] [RL8]
				end else begin
					ok_d = 1'b1;
				end
				win_d  = '0;
				ones_d = '0;
			end
		end else if (hif.restart) begin
			run_d  = '0;
			win_d  = '0;
			ones_d = '0;
		end
	end

	// register
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			last_q <= 1'b0;
			run_q  <= '0;
			win_q  <= '0;
			ones_q <= '0;
			fail_q <= 1'b0;
			def_q  <= 1'b0;
			ok_q   <= 1'b0;
		end else begin
			last_q <= last_d;
			run_q  <= run_d;
			win_q  <= win_d;
			ones_q <= ones_d;
			fail_q <= fail_d;
			def_q  <= def_d;
			ok_q   <= ok_d;
		end
	end

	assign hif.total_fail = fail_q;
	assign hif.defect     = def_q;
	assign hif.win_ok     = ok_q;

endmodule // prg_health

// ==== design/prg_gate_top.sv ====
// gate for physical random words: sampling, word assembly and health gating
`timescale 1ns/10ps

// Functional notes
// RL1 - stuck-source test runs from start and flags a dead source at once
// RL2 - after a total failure no random word is delivered
// RL3 - words holding bits taken after a failure are discarded
// RL4 - statistical test runs on raw bits at start and during operation
// RL5 - no output until power-up test passes, nor while a defect is flagged
// RL6 - health tests run on every raw sample, not on request
// RL7 - output is delivered as 32-bit words
// RL8 - bias bound keeps entropy per bit above 0.96
// RL9 - word valid only while gates allow; consumer takes only when valid
module prg_gate_top
	import prg_pkg::*;
#(
	parameter int unsigned WORD_W = PRG_WORD_W
) (
	// clock and reset
	input  wire logic              clk_in,
	input  wire logic              reset_n_in,
	// raw entropy source, asynchronous
	input  wire logic              raw_bit_in,
	// control from the consumer side
	input  wire logic              restart_in,
	// random word stream
	output logic [WORD_W-1:0]      word_out,
	output logic                   word_valid_out,
	input  wire logic              word_ready_in,
	// health status
	output logic                   total_fail_out,
	output logic                   defect_out,
	output logic                   running_out
);

	// ****************************************************************
	// raw bit synchroniser
	// ****************************************************************
	logic sync1_q;
	logic sync2_q;

	// second flop alone feeds logic; the first may be metastable
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= raw_bit_in;
			sync2_q <= sync1_q;
		end
	end

	// ****************************************************************
	// sample divider
	// ****************************************************************
	logic [PRG_DIV_W-1:0] div_q, div_d;
	logic                 smp;

	// spacing samples lets the analog source decorrelate between bits
	always_comb begin
		if (div_q == PRG_DIV_W'(PRG_SAMPLE_DIV - 1)) begin
			div_d = '0;
		end else begin
			div_d = div_q + 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	assign smp = (div_q == '0);

	// ****************************************************************
	// health engine
	// ****************************************************************
	prg_health_if hif ();

	prg_health u_health (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.hif        (hif.health)
	);

	prg_state_t            state_q, state_d;
	logic                  restart_q, restart_d;

	assign hif.sample_stb = smp;  // [RL4] [RL6]
	assign hif.sample_bit = sync2_q;
	assign hif.restart    = restart_q;

	// ****************************************************************
	// word assembly and gating
	// ****************************************************************
	localparam int unsigned CNT_W = $clog2(WORD_W);

	logic [WORD_W-1:0]     shift_q, shift_d;
	logic [CNT_W-1:0]      cnt_q,   cnt_d;
	logic [WORD_W-1:0]     pend_q,  pend_d;
	logic                  pend_v_q, pend_v_d;
	logic [WORD_W-1:0]     out_q,   out_d;
	logic                  out_v_q, out_v_d;
	logic [PRG_PASS_W-1:0] pass_q,  pass_d;
	logic                  fail_q,  fail_d;
	logic                  def_q,   def_d;

	// a finished word is held back one more word time; the stuck test
	// fires within the cutoff, shorter than a word, so a word whose bits
	// follow a failure is always caught before it is released
	always_comb begin
		state_d   = state_q;
		restart_d = 1'b0;
		shift_d   = shift_q;
		cnt_d     = cnt_q;
		pend_d    = pend_q;
		pend_v_d  = pend_v_q;
		out_d     = out_q;
		out_v_d   = out_v_q;
		pass_d    = pass_q;
		fail_d    = fail_q;
		def_d     = def_q;

		// consumer takes the word only while valid is high
		if (out_v_q && word_ready_in) begin
			out_v_d = 1'b0;  // [RL9]
		end

		// assemble raw bits into words
		if (smp && state_q != PRG_ST_DEAD) begin
			shift_d = {shift_q[WORD_W-2:0], sync2_q};
			cnt_d   = cnt_q + 1'b1;
			if (cnt_q == CNT_W'(WORD_W - 1)) begin
				// release the older word only when running and the last one is gone;
				// a take never shares its edge with a launch, so valid drops after it
				if (pend_v_q && state_q == PRG_ST_RUN && !out_v_q) begin
					out_d   = pend_q;  // [RL7]
					out_v_d = 1'b1;
				end
				pend_d   = shift_d;
				pend_v_d = 1'b1;
			end
		end

		unique case (state_q)
			PRG_ST_TEST: begin
				// power-up test: count clean windows
				if (hif.win_ok) begin
					if (pass_q == PRG_PASS_W'(PRG_PWRUP_WINS - 1)) begin
						state_d = PRG_ST_RUN;  // [RL5]
						def_d   = 1'b0;
						pass_d  = '0;
					end else begin
						pass_d = pass_q + 1'b1;
					end
				end
			end
			PRG_ST_RUN: begin
				pass_d = '0;
			end
			PRG_ST_DEAD: begin
				// only an explicit restart leaves the dead state
				if (restart_in) begin
					state_d   = PRG_ST_TEST;
					restart_d = 1'b1;
					fail_d    = 1'b0;
					def_d     = 1'b0;
				end
			end
		endcase

		// a defect withholds output and re-runs the power-up test
		if (hif.defect && state_q != PRG_ST_DEAD) begin
			state_d  = PRG_ST_TEST;  // [RL5]
			def_d    = 1'b1;
			pass_d   = '0;
			pend_v_d = 1'b0;
			out_v_d  = 1'b0;
		end

		// total failure beats everything and drops held words
		if (hif.total_fail) begin
			state_d  = PRG_ST_DEAD;  // [RL1] [RL2]
			fail_d   = 1'b1;
			pend_v_d = 1'b0;  // [RL3]
			out_v_d  = 1'b0;  // [RL3]
			cnt_d    = '0;
		end
	end

	// register gate state
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			state_q   <= PRG_ST_TEST;
			restart_q <= 1'b0;
			shift_q   <= PRG_WORD_RST[WORD_W-1:0];
			cnt_q     <= '0;
			pend_q    <= PRG_WORD_RST[WORD_W-1:0];
			pend_v_q  <= 1'b0;
			out_q     <= PRG_WORD_RST[WORD_W-1:0];
			out_v_q   <= 1'b0;
			pass_q    <= '0;
			fail_q    <= 1'b0;
			def_q     <= 1'b0;
		end else begin
			state_q   <= state_d;
			restart_q <= restart_d;
			shift_q   <= shift_d;
			cnt_q     <= cnt_d;
			pend_q    <= pend_d;
			pend_v_q  <= pend_v_d;
			out_q     <= out_d;
			out_v_q   <= out_v_d;
			pass_q    <= pass_d;
			fail_q    <= fail_d;
			def_q     <= def_d;
		end
	end

	// ****************************************************************
	// outputs, all straight from flops
	// ****************************************************************
	assign word_out       = out_q;
	assign word_valid_out = out_v_q;  // [RL9]
	assign total_fail_out = fail_q;
	assign defect_out     = def_q;

	// running flag registered on its own to keep the output a flop
	logic run_q, run_d;

	always_comb begin
		run_d = (state_d == PRG_ST_RUN);
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			run_q <= 1'b0;
		end else begin
			run_q <= run_d;
		end
	end

	assign running_out = run_q;

endmodule // prg_gate_top

// ==== bench/prg_gate_top_assertions.sv ====
// port checker for the random word gate
`timescale 1ns/10ps
module prg_gate_chk #(
	parameter int unsigned WORD_W = 32
) (
	input wire logic              clk_in,
	input wire logic              reset_n_in,
	input wire logic              raw_bit_in,
	input wire logic              restart_in,
	input wire logic [WORD_W-1:0] word_out,
	input wire logic              word_valid_out,
	input wire logic              word_ready_in,
	input wire logic              total_fail_out,
	input wire logic              defect_out,
	input wire logic              running_out
);
	logic [7:0] gap_q, gap_d, run_q, run_d;
	logic       v_q, raw_q;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	// cycles since the last word launch, length of a constant raw run
	always_comb begin
		gap_d = (word_valid_out && !v_q) ? 8'h00 : gap_q + {7'h00, gap_q != 8'hff};
		run_d = (raw_bit_in == raw_q) ? run_q + {7'h00, run_q != 8'hff} : 8'h00;
	end
	// saturating, so long idle spans never wrap back into range
	always_ff @(posedge clk_in) begin
		gap_q <= reset_n_in ? gap_d : 8'hff;
		run_q <= reset_n_in ? run_d : 8'h00;
		v_q   <= reset_n_in && word_valid_out;
		raw_q <= raw_bit_in;
	end

	a_valid_needs_run: assert property (word_valid_out |-> running_out)
		else $error("word valid outside run");
	a_no_word_dead: assert property (total_fail_out |-> !word_valid_out)
		else $error("word valid after total failure");
	a_no_word_defect: assert property (defect_out |-> !word_valid_out)
		else $error("word valid with defect");
	a_run_clean: assert property (running_out |-> !defect_out && !total_fail_out)
		else $error("running with a fault flag");
	a_word_holds: assert property (word_valid_out && !word_ready_in ##1 word_valid_out
		|-> $stable(word_out)) else $error("word changed before taken");
	a_take_drops: assert property (word_valid_out && word_ready_in |=> !word_valid_out)
		else $error("valid kept after take");
	a_word_spacing: assert property ($rose(word_valid_out) |-> gap_q >= 8'h7f)
		else $error("words closer than one word time");
	a_stuck_flags: assert property (run_q == 8'h6e |-> total_fail_out)
		else $error("stuck source not flagged");
	a_restart_clears: assert property (restart_in && total_fail_out |-> ##[1:2] !total_fail_out)
		else $error("restart left failure set");
endmodule // prg_gate_chk

bind prg_gate_top prg_gate_chk #(.WORD_W(WORD_W)) i_prg_gate_chk (
	.clk_in(clk_in), .reset_n_in(reset_n_in), .raw_bit_in(raw_bit_in),
	.restart_in(restart_in), .word_out(word_out), .word_valid_out(word_valid_out),
	.word_ready_in(word_ready_in), .total_fail_out(total_fail_out),
	.defect_out(defect_out), .running_out(running_out));

// ==== bench/prg_consumer.sv ====
// consumer model: takes random words while valid, may stall
`timescale 1ns/10ps
module prg_consumer
	import prg_pkg::*;
(
	input  wire logic                  clk_in,
	input  wire logic                  stall_in,
	input  wire logic [PRG_WORD_W-1:0] word_in,
	input  wire logic                  valid_in,
	output logic                       ready_out,
	output int                         taken_out,
	output logic [PRG_WORD_W-1:0]      last_out,
	output logic [PRG_WORD_W-1:0]      prev_out
);
	initial begin
		taken_out = 0;
		ready_out = 1'h0;
		last_out  = '0;
		prev_out  = '0;
	end
	// ready moves off the sampling edge and is held between takes
	always @(negedge clk_in) begin
		ready_out <= !stall_in;
	end
	// a word counts only at an edge where valid and ready meet
	always @(posedge clk_in) begin
		if (valid_in && ready_out) begin
			taken_out <= taken_out + 1;
			prev_out  <= last_out;
			last_out  <= word_in;
		end
	end
endmodule // prg_consumer

// ==== bench/tb_prg_gate_top.sv ====
// testbench for the random word gate
`timescale 1ns/10ps
module tb_prg_gate_top;
	import prg_pkg::*;
	logic                  clk_in = 0, reset_n_in = 0, raw_bit_in = 0, restart_in = 0, stall = 0;
	logic [PRG_WORD_W-1:0] word_out;
	logic [PRG_WORD_W-1:0] last_w, prev_w;
	logic                  word_valid_out, word_ready_in, total_fail_out, defect_out, running_out;
	logic [15:0]           lfsr = 16'hace1;
	int                    mode = 0, clk_n = 0, taken, tk, n, mismatches = 0, tests_run = 0;

	prg_gate_top #(.WORD_W(PRG_WORD_W)) i_prg_gate_top (.clk_in(clk_in),
		.reset_n_in(reset_n_in), .raw_bit_in(raw_bit_in), .restart_in(restart_in),
		.word_out(word_out), .word_valid_out(word_valid_out), .word_ready_in(word_ready_in),
		.total_fail_out(total_fail_out), .defect_out(defect_out), .running_out(running_out));
	prg_consumer i_prg_consumer (.clk_in(clk_in), .stall_in(stall), .word_in(word_out),
		.valid_in(word_valid_out), .ready_out(word_ready_in), .taken_out(taken),
		.last_out(last_w), .prev_out(prev_w));

	always #12.5 clk_in = ~clk_in;
	// raw source: healthy lfsr, stuck high, or biased three ones in four
	always @(negedge clk_in) begin
		clk_n <= clk_n + 1;
		lfsr  <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		case (mode)
			0: raw_bit_in <= lfsr[0];
			1: raw_bit_in <= 1'h1;
			default: raw_bit_in <= ((clk_n / 4) % 4) != 3;
		endcase
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic pick(input int w);
		return w == 0 ? running_out : (w == 1 ? total_fail_out : defect_out);
	endfunction
	// bounded wait for a status flag; n holds the cycles spent
	task automatic wait_flag(input int w, input int lim);
		n = 0;
		while (pick(w) !== 1'h1 && n < lim) begin
			@(negedge clk_in);
			n++;
		end
	endtask
	task automatic test_done;
		$display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// power-up hold, then words flow, stall holds the word
	task automatic t_powerup;
		wait_flag(0, 12000);
		check(n >= 8000, 1);
		check(running_out, 1);
		repeat (700) @(negedge clk_in);
		check(taken >= 4, 1);
		// a healthy source never repeats a word or fills one with a single level
		check(last_w != prev_w, 1);
		check(last_w != '0 && last_w != '1, 1);
		stall = 1;
		repeat (400) @(negedge clk_in);
		tk = taken;
		repeat (300) @(negedge clk_in);
		check(taken, tk);
		check(word_valid_out, 1);
		stall = 0;
	endtask
	// biased stream in operation is caught and output held
	task automatic t_defect;
		mode = 2;
		wait_flag(2, 9000);
		check(defect_out, 1);
		check(running_out, 0);
		tk = taken;
		repeat (300) @(negedge clk_in);
		check(taken, tk);
		mode = 0;
		wait_flag(0, 25000);
		check(defect_out, 0);
	endtask
	// stuck source: failure is sticky until restart
	task automatic t_stuck;
		mode = 1;
		wait_flag(1, 200);
		check(n <= 110, 1);
		check(word_valid_out, 0);
		tk = taken;
		// keep the source stuck past the flag deadline so the checker sees it
		repeat (20) @(negedge clk_in);
		mode = 0;
		repeat (1000) @(negedge clk_in);
		check(taken, tk);
		check(total_fail_out, 1);
		restart_in = 1;
		@(negedge clk_in);
		restart_in = 0;
		repeat (2) @(negedge clk_in);
		check(total_fail_out, 0);
		wait_flag(0, 12000);
		check(running_out, 1);
	endtask

	initial begin
		repeat (10) @(negedge clk_in);
		reset_n_in = 1;
		t_powerup;
		t_defect;
		t_stuck;
		test_done;
	end
	// watchdog: the whole sequence needs about 30000 cycles
	initial begin
		#1750000;
		mismatches++;
		test_done;
	end
endmodule // tb_prg_gate_top
